// ==== include/dst_regs.svh ====
/*
  Register map, field positions, reset values and timing figures of the
  deep-sleep timer block.
  Assumes inclusion by bare name from the design files only.
*/
`ifndef DST_REGS_SVH
`define DST_REGS_SVH

// ************************************************************
// Register byte addresses
// ************************************************************
`define DST_OFS_BASE_SNAP   32'h4000001c
`define DST_OFS_FINE_SNAP   32'h40000020
`define DST_OFS_ADDR_LOW    32'h40000024
`define DST_OFS_ADDR_HIGH   32'h40000028
`define DST_OFS_POINTERS    32'h4000002c
`define DST_OFS_CONTROL     32'h40000030
`define DST_OFS_SLEEP_LEN   32'h40000034
`define DST_OFS_SLEEP_DUR   32'h40000038
`define DST_OFS_WAKE_TIMING 32'h4000003c

// ************************************************************
// Field positions
// ************************************************************
`define DST_CTL_EXT_BLOCK_BIT 31
`define DST_CTL_STATUS_BIT    15
`define DST_CTL_SOFT_WAKE_BIT 4
`define DST_CTL_CORR_BIT      3
`define DST_CTL_SLEEP_ON_BIT  2
`define DST_CTL_IRQ_EN_MSB    1
`define DST_CTL_IRQ_EN_LSB    0
`define DST_ADDR_PRIV_BIT     16
`define DST_IRQ_EN_ALL        2'h3

// ************************************************************
// Reset values and timing
// ************************************************************
`define DST_RST_WORD        32'h00000000
`define DST_RST_TB_RUN      1'b1
`define DST_BASE_PERIOD_US  625
`define DST_FINE_LAST       (`DST_BASE_PERIOD_US - 1)

`endif

// ==== include/dst_pkg.sv ====
/*
  Types shared by the deep-sleep timer design files.
  Assumes nothing of its surroundings.
*/
package dst_pkg;

  // Sleep sequencer states, one-hot
  typedef enum logic [2:0] {
    DST_ST_ACTIVE = 3'b001,
    DST_ST_SLEEP  = 3'b010,
    DST_ST_WOKEN  = 3'b100
  } dst_state_t;

  // Classic Wishbone request as seen by the slave
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [31:0] adr;
    logic [31:0] dat;
  } dst_wb_req_t;

  // Software-held control bits
  typedef struct packed {
    logic       ext_block;
    logic       soft_wake;
    logic       sleep_on;
    logic [1:0] irq_en;
  } dst_ctrl_t;

  // Upper address register contents
  typedef struct packed {
    logic        addr_priv;
    logic [15:0] addr_hi;
  } dst_addr_hi_t;

  // Pointer register contents
  typedef struct packed {
    logic [15:0] exch_start;
    logic [14:0] rx_start;
  } dst_ptr_t;

  // Wake interrupt timing word, laid out as the register
  typedef struct packed {
    logic [10:0] ext_delay;
    logic [10:0] assert_lead;
    logic [9:0]  release_lead;
  } dst_timing_t;

endpackage

// ==== design/dst_timebase.sv ====
/*
  Fine microsecond counter and coarse slot counter of the link core.
  Assumes a one-cycle microsecond strobe synchronous to the clock.
*/
`timescale 1ns/1ns
`include "dst_regs.svh"

module dst_timebase #(
  parameter int unsigned FINE_W = 10,
  parameter int unsigned BASE_W = 27
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic us_tick,
  input wire logic run,
  output logic [FINE_W-1:0] fine,
  output logic [BASE_W-1:0] base
);

  // ************************************************************
  // Counters
  // ************************************************************
  logic [FINE_W-1:0] fine_q, fine_d; // Microseconds inside a slot
  logic [BASE_W-1:0] base_q, base_d; // Whole slots

  // Next values: fine wraps at the end of a slot and carries
  always_comb begin
    fine_d = fine_q;
    base_d = base_q;
    if (run && us_tick) begin
      if (fine_q == FINE_W'(`DST_FINE_LAST)) begin
        fine_d = '0;
        base_d = base_q + BASE_W'(1);
      end else begin
        fine_d = fine_q + FINE_W'(1);
      end
    end
  end

  // Register stage
  always_ff @(posedge clk) begin
    if (rst) begin
      fine_q <= '0;
      base_q <= '0;
    end else begin
      fine_q <= fine_d;
      base_q <= base_d;
    end
  end

  assign fine = fine_q;
  assign base = base_q;

endmodule

// ==== design/dst_elapsed.sv ====
/*
  Measured sleep length counter.
  Assumes clear and increment strobes from the sleep sequencer.
*/
`timescale 1ns/1ns

module dst_elapsed #(
  parameter int unsigned CNT_W = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic inc,
  output logic [CNT_W-1:0] count
);

  // ************************************************************
  // Counter
  // ************************************************************
  logic [CNT_W-1:0] cnt_q, cnt_d; // Low-power cycles seen

  // Clear wins over increment
  always_comb begin
    cnt_d = cnt_q;
    if (clear) begin
      cnt_d = '0;
    end else if (inc) begin
      cnt_d = cnt_q + CNT_W'(1);
    end
  end

  // Register stage
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign count = cnt_q;

endmodule

// ==== design/dst_top.sv ====
/*
  Deep-sleep timer and wake-up control of the radio link core, with
  time snapshots, device address and pointer registers, on Wishbone.
  Assumes LP_TICK and US_TICK are one-cycle strobes synchronous to
  CORE_CLK, and EXT_WAKE_REQ is a synchronous level.
*/
`timescale 1ns/1ns
`include "dst_regs.svh"

//  Function
// - Coarse slot count snapshot on sample write
// - Microsecond count snapshot on sample write
// - Hold 48-bit device address in two words
// - Bit 16 marks address private
// - Exchange table and receive list pointers
// - Bit 31 blocks external wake requests
// - Bit 15 reads one only asleep
// - Software wake request, self-clearing on wake
// - Correction write re-enables counters after wake
// - Sleep request clears when status falls
// - Sleep for programmed low-power cycle count
// - Measure sleep length in low-power cycles
// - Raise wake interrupt at assert lead
// - Drop wake interrupt at release lead
// - External wake drops interrupt after delay
module dst_top #(
  parameter int unsigned LEN_W = 32
) (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic LP_TICK,
  input wire logic US_TICK,
  input wire logic EXT_WAKE_REQ,
  output logic DEEP_SLEEP_ACTIVE,
  output logic WAKE_INTERRUPT,
  output logic TIMEBASE_RUN
);

  // ************************************************************
  // Helper functions
  // ************************************************************

  // Address match against one register
  function automatic logic is_hit(input logic [31:0] adr, input logic [31:0] ofs);
    is_hit = (adr == ofs);
  endfunction

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    wmerge = res;
  endfunction

  // ************************************************************
  // Bus request and decode
  // ************************************************************
  dst_pkg::dst_wb_req_t req; // Bundled request
  logic ack_q, ack_d; // Acknowledge flop
  logic [31:0] rdat_q, rdat_d; // Read data flop
  logic acc_new; // Fresh access this cycle
  logic wr_en; // Write takes effect at this edge
  logic hit_base, hit_fine, hit_alo, hit_ahi, hit_ptr;
  logic hit_ctl, hit_len, hit_dur, hit_tim;

  assign req = {WB_CYC_I, WB_STB_I, WB_WE_I, WB_SEL_I, WB_ADR_I, WB_DAT_I};
  assign acc_new = req.cyc & req.stb & ~ack_q;
  assign wr_en = acc_new & req.we;
  assign hit_base = is_hit(req.adr, `DST_OFS_BASE_SNAP);
  assign hit_fine = is_hit(req.adr, `DST_OFS_FINE_SNAP);
  assign hit_alo = is_hit(req.adr, `DST_OFS_ADDR_LOW);
  assign hit_ahi = is_hit(req.adr, `DST_OFS_ADDR_HIGH);
  assign hit_ptr = is_hit(req.adr, `DST_OFS_POINTERS);
  assign hit_ctl = is_hit(req.adr, `DST_OFS_CONTROL);
  assign hit_len = is_hit(req.adr, `DST_OFS_SLEEP_LEN);
  assign hit_dur = is_hit(req.adr, `DST_OFS_SLEEP_DUR);
  assign hit_tim = is_hit(req.adr, `DST_OFS_WAKE_TIMING);

  // ************************************************************
  // State declarations
  // ************************************************************
  logic [31:0] addr_lo_q, addr_lo_d; // Low address word
  dst_pkg::dst_addr_hi_t addr_hi_q, addr_hi_d; // High address and flag
  dst_pkg::dst_ptr_t ptr_q, ptr_d; // Table and list pointers
  dst_pkg::dst_ctrl_t ctrl_q, ctrl_d; // Control bits
  logic [LEN_W-1:0] len_q, len_d; // Programmed sleep length
  dst_pkg::dst_timing_t tim_q, tim_d; // Interrupt timing
  logic [26:0] snap_base_q, snap_base_d; // Slot count snapshot
  logic [9:0] snap_fine_q, snap_fine_d; // Microsecond snapshot
  dst_pkg::dst_state_t state_q, state_d; // Sleep sequencer
  logic [LEN_W-1:0] remain_q, remain_d; // Cycles left asleep
  logic irq_q, irq_d; // Wake interrupt level
  logic [10:0] ext_cnt_q, ext_cnt_d; // External release countdown
  logic ext_run_q, ext_run_d; // External countdown busy
  logic run_tb_q, run_tb_d; // Time base enable
  logic status_q, status_d; // Asleep indicator
  logic enter; // Sleep begins at this edge
  logic leave; // Sleep ends at this edge
  logic expired; // Sleep timer reached zero
  logic ext_ok; // Unblocked external wake
  logic corr_wr; // Correction bit written with one
  logic [31:0] ctl_word; // Control register as read
  logic [31:0] ctl_wr; // Control word after a write
  logic [31:0] ptr_wr; // Pointer word after a write
  logic [9:0] tb_fine; // Live microsecond count
  logic [26:0] tb_base; // Live slot count
  logic [LEN_W-1:0] elapsed; // Measured sleep length

  // ************************************************************
  // Submodules
  // ************************************************************

  // Live time base, frozen during sleep
  dst_timebase #(
    .FINE_W(10),
    .BASE_W(27)
  ) u_timebase (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .us_tick(US_TICK),
    .run(run_tb_q),
    .fine(tb_fine),
    .base(tb_base)
  );

  // Cleared on entry, counts while asleep
  dst_elapsed #(
    .CNT_W(LEN_W)
  ) u_elapsed (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .clear(enter),
    .inc(status_q & LP_TICK & ~leave),
    .count(elapsed)
  );

  // ************************************************************
  // Register file
  // ************************************************************
  assign ctl_word = {ctrl_q.ext_block, 15'h0000, status_q, 10'h000, ctrl_q.soft_wake, 1'b0,
                     ctrl_q.sleep_on, ctrl_q.irq_en};
  assign ctl_wr = wmerge(ctl_word, req.dat, req.sel);
  assign ptr_wr = wmerge({ptr_q.exch_start, 1'b0, ptr_q.rx_start}, req.dat, req.sel);
  assign corr_wr = wr_en & hit_ctl & ctl_wr[`DST_CTL_CORR_BIT];

  // Next register values from bus writes and hardware events
  always_comb begin
    addr_lo_d = addr_lo_q;
    addr_hi_d = addr_hi_q;
    ptr_d = ptr_q;
    ctrl_d = ctrl_q;
    len_d = len_q;
    tim_d = tim_q;
    snap_base_d = snap_base_q;
    snap_fine_d = snap_fine_q;
    if (wr_en && hit_base) begin
      snap_base_d = tb_base;
      snap_fine_d = tb_fine;
    end
    if (wr_en && hit_alo) begin
      addr_lo_d = wmerge(addr_lo_q, req.dat, req.sel);
    end
    if (wr_en && hit_ahi) begin
      addr_hi_d = 17'(wmerge({15'h0000, addr_hi_q}, req.dat, req.sel));
    end
    if (wr_en && hit_ptr) begin
      ptr_d = {ptr_wr[31:16], ptr_wr[14:0]};
    end
    if (wr_en && hit_len) begin
      len_d = wmerge(len_q, req.dat, req.sel);
    end
    if (wr_en && hit_tim) begin
      tim_d = wmerge(tim_q, req.dat, req.sel);
    end
    // Wake request clears once the wake is done
    if (leave) begin
      ctrl_d.soft_wake = 1'b0;
    end
    // Sleep request clears as status falls
    if (leave) begin
      ctrl_d.sleep_on = 1'b0;
    end
    // Control writes; a written sleep request wins over the clear, a written wake request does not
    if (wr_en && hit_ctl) begin
      ctrl_d.ext_block = ctl_wr[`DST_CTL_EXT_BLOCK_BIT];
      ctrl_d.irq_en = ctl_wr[`DST_CTL_IRQ_EN_MSB:`DST_CTL_IRQ_EN_LSB];
      if (ctl_wr[`DST_CTL_SLEEP_ON_BIT] || !leave) begin
        ctrl_d.sleep_on = ctl_wr[`DST_CTL_SLEEP_ON_BIT];
      end
      // Wake request only counts while asleep
      if (state_q == dst_pkg::DST_ST_SLEEP && !leave && ctl_wr[`DST_CTL_SOFT_WAKE_BIT]) begin
        ctrl_d.soft_wake = 1'b1;
      end
    end
  end

  // Register stage of the register file
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      addr_lo_q <= `DST_RST_WORD;
      addr_hi_q <= 17'h00000;
      ptr_q <= 31'h00000000;
      ctrl_q <= 5'h00;
      len_q <= `DST_RST_WORD;
      tim_q <= `DST_RST_WORD;
      snap_base_q <= 27'h0000000;
      snap_fine_q <= 10'h000;
    end else begin
      addr_lo_q <= addr_lo_d;
      addr_hi_q <= addr_hi_d;
      ptr_q <= ptr_d;
      ctrl_q <= ctrl_d;
      len_q <= len_d;
      tim_q <= tim_d;
      snap_base_q <= snap_base_d;
      snap_fine_q <= snap_fine_d;
    end
  end

  // ************************************************************
  // Bus answer
  // ************************************************************

  // One-cycle ack; unmapped reads return zero, writes dropped
  always_comb begin
    ack_d = acc_new;
    rdat_d = rdat_q;
    if (acc_new) begin
      rdat_d = 32'h00000000;
      if (hit_base) begin
        rdat_d = {5'h00, snap_base_q};
      end else if (hit_fine) begin
        rdat_d = {22'h000000, snap_fine_q};
      end else if (hit_alo) begin
        rdat_d = addr_lo_q;
      end else if (hit_ahi) begin
        rdat_d = {15'h0000, addr_hi_q};
      end else if (hit_ptr) begin
        rdat_d = {ptr_q.exch_start, 1'b0, ptr_q.rx_start};
      end else if (hit_ctl) begin
        rdat_d = ctl_word;
      end else if (hit_len) begin
        rdat_d = len_q;
      end else if (hit_dur) begin
        rdat_d = elapsed;
      end else if (hit_tim) begin
        rdat_d = tim_q;
      end
    end
  end

  // Register stage of the bus answer
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  // ************************************************************
  // Sleep sequencer
  // ************************************************************

  // Timer runs out when no cycles remain
  assign expired = (remain_q == '0);
  assign ext_ok = EXT_WAKE_REQ & ~ctrl_q.ext_block;

  // Next sequencer values
  always_comb begin
    state_d = state_q;
    remain_d = remain_q;
    irq_d = irq_q;
    ext_cnt_d = ext_cnt_q;
    ext_run_d = ext_run_q;
    run_tb_d = run_tb_q;
    enter = 1'b0;
    leave = 1'b0;
    // External release countdown to interrupt drop
    if (ext_run_q) begin
      if (ext_cnt_q == 11'h000) begin
        irq_d = 1'b0;
        ext_run_d = 1'b0;
      end else if (LP_TICK) begin
        ext_cnt_d = ext_cnt_q - 11'h001;
      end
    end
    case (state_q)
      // Awake; a sleep request starts the sleep
      dst_pkg::DST_ST_ACTIVE: begin
        if (ctrl_q.sleep_on) begin
          state_d = dst_pkg::DST_ST_SLEEP;
          remain_d = len_q;
          run_tb_d = 1'b0;
          enter = 1'b1;
        end
      end
      // Asleep until the first wake event
      dst_pkg::DST_ST_SLEEP: begin
        // Expiry, software or external wake ends sleep
        if (expired || ctrl_q.soft_wake || ext_ok) begin
          state_d = dst_pkg::DST_ST_WOKEN;
          leave = 1'b1;
          if (ext_ok && !expired) begin
            irq_d = 1'b1;
            ext_cnt_d = tim_q.ext_delay;
            ext_run_d = 1'b1;
          end
        end else begin
          // Count down one per low-power cycle
          if (LP_TICK) begin
            remain_d = remain_q - LEN_W'(1);
          end
          if (ctrl_q.irq_en == `DST_IRQ_EN_ALL) begin
            if (remain_q == LEN_W'(tim_q.release_lead)) begin
              irq_d = 1'b0;
            end else if (remain_q == LEN_W'(tim_q.assert_lead)) begin
              irq_d = 1'b1;
            end
          end
        end
      end
      // Woken; correction write restarts the time base
      dst_pkg::DST_ST_WOKEN: begin
        if (corr_wr) begin
          state_d = dst_pkg::DST_ST_ACTIVE;
          run_tb_d = 1'b1;
        end
      end
      default: begin
        state_d = dst_pkg::DST_ST_ACTIVE;
      end
    endcase
    // Status high only in the sleep state
    status_d = (state_d == dst_pkg::DST_ST_SLEEP);
  end

  // Register stage of the sequencer
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      state_q <= dst_pkg::DST_ST_ACTIVE;
      remain_q <= '0;
      irq_q <= 1'b0;
      ext_cnt_q <= 11'h000;
      ext_run_q <= 1'b0;
      run_tb_q <= `DST_RST_TB_RUN;
      status_q <= 1'b0;
    end else begin
      state_q <= state_d;
      remain_q <= remain_d;
      irq_q <= irq_d;
      ext_cnt_q <= ext_cnt_d;
      ext_run_q <= ext_run_d;
      run_tb_q <= run_tb_d;
      status_q <= status_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rdat_q;
  assign DEEP_SLEEP_ACTIVE = status_q;
  assign WAKE_INTERRUPT = irq_q;
  assign TIMEBASE_RUN = run_tb_q;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking dst_cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SYS_RST);

  a_snap_base_load: assert property (wr_en && hit_base |=> snap_base_q == $past(tb_base))
    else $error("Slot snapshot not taken");
  a_snap_fine_load: assert property (wr_en && hit_fine == 1'b0 && hit_base |=>
    snap_fine_q == $past(tb_fine))
    else $error("Microsecond snapshot not taken");
  a_addr_low_store: assert property (wr_en && hit_alo && req.sel == 4'hf |=>
    addr_lo_q == $past(req.dat))
    else $error("Low address not stored");
  a_priv_flag_store: assert property (wr_en && hit_ahi && req.sel[2] |=>
    addr_hi_q.addr_priv == $past(req.dat[`DST_ADDR_PRIV_BIT]))
    else $error("Privacy flag not stored");
  a_ext_wake_block: assert property (state_q == dst_pkg::DST_ST_SLEEP && EXT_WAKE_REQ &&
    ctrl_q.ext_block && !ctrl_q.soft_wake && !expired |=> DEEP_SLEEP_ACTIVE)
    else $error("Blocked external wake ended sleep");
  a_status_state: assert property (DEEP_SLEEP_ACTIVE == (state_q == dst_pkg::DST_ST_SLEEP))
    else $error("Status disagrees with sleep state");
  a_soft_wake_exit: assert property (DEEP_SLEEP_ACTIVE && ctrl_q.soft_wake |=>
    !DEEP_SLEEP_ACTIVE && !ctrl_q.soft_wake)
    else $error("Software wake not honoured");
  a_corr_restart: assert property (state_q == dst_pkg::DST_ST_WOKEN && corr_wr |=>
    TIMEBASE_RUN && state_q == dst_pkg::DST_ST_ACTIVE)
    else $error("Correction did not restart time base");
  a_sleep_req_clear: assert property ($fell(DEEP_SLEEP_ACTIVE) |->
    !ctrl_q.sleep_on || $past(wr_en && hit_ctl))
    else $error("Sleep request survived wake");
  a_expiry_exit: assert property (DEEP_SLEEP_ACTIVE && expired |=> !DEEP_SLEEP_ACTIVE)
    else $error("Expired timer did not wake");
  a_elapsed_count: assert property (DEEP_SLEEP_ACTIVE && LP_TICK && !leave |=>
    elapsed == $past(elapsed) + LEN_W'(1))
    else $error("Sleep length not counted");
  a_irq_assert_lead: assert property (DEEP_SLEEP_ACTIVE && !leave && ctrl_q.irq_en == 2'h3 &&
    remain_q == LEN_W'(tim_q.assert_lead) && tim_q.assert_lead != 11'(tim_q.release_lead)
    |=> WAKE_INTERRUPT)
    else $error("Wake interrupt not raised at lead");
  a_irq_ext_release: assert property (ext_run_q && ext_cnt_q == 11'h000 |=> !WAKE_INTERRUPT)
    else $error("External wake interrupt not released");

endmodule

// ==== design/dst_top_fix_note.sv ====
`timescale 1ns/1ns

// ==== bench/dst_lp_model.sv ====
/*
  Far-side model: low-power clock ticks, microsecond ticks and the
  external wake line. Assumes the bench clock and reset.
*/
`timescale 1ns/1ns
module dst_lp_model #(
  parameter int LP_DIV = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ext_cmd,
  output logic lp_tick,
  output logic us_tick,
  output logic ext_wake
);
  int cnt_q; // Tick divider
  // One-cycle strobes, ext line follows the bench command
  always_ff @(posedge clk) begin
    cnt_q <= (rst || cnt_q == LP_DIV - 1) ? 0 : cnt_q + 1;
    lp_tick <= !rst && cnt_q == LP_DIV - 1;
    us_tick <= !rst && cnt_q[0];
    ext_wake <= !rst && ext_cmd;
  end
endmodule

// ==== bench/tb_top.sv ====
/*
  Self-checking bench of the deep-sleep timer.
  Assumes dst_top and the far-side model.
*/
`timescale 1ns/1ns
module tb_top;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ext = 0;
  logic [3:0] sel = 4'h0;
  logic [31:0] adr = 32'h0, wd = 32'h0, rd, dat_o;
  logic ack, lp, us, xw, sleep_o, irq_o, run_o;
  int err_total = 0, n_checks = 0;
  int waited = 0; // Cycles spent in the last level wait
  localparam int LP_DIV = 4; // Core cycles per low-power cycle
  always #5 clk = ~clk; // 100 MHz
  dst_lp_model #(.LP_DIV(LP_DIV)) i_dst_lp_model (.clk(clk), .rst(rst), .ext_cmd(ext), .lp_tick(lp), .us_tick(us),
    .ext_wake(xw));
  dst_top i_dst_top (.CORE_CLK(clk), .SYS_RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_SEL_I(sel), .WB_ADR_I(adr), .WB_DAT_I(wd), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .LP_TICK(lp),
    .US_TICK(us), .EXT_WAKE_REQ(xw), .DEEP_SLEEP_ACTIVE(sleep_o), .WAKE_INTERRUPT(irq_o), .TIMEBASE_RUN(run_o));
  // ************************************************************
  // Helpers
  // ************************************************************
  task summarize;
    if (err_total == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  // Classic single cycle, held until ack
  task wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wd <= d;
    sel <= 4'hf;
    // Ack is looked at mid-cycle, where it has settled
    @(negedge clk);
    while (ack !== 1'b1) begin
      n++;
      if (n > 50) begin
        err_total++;
        summarize();
      end
      @(negedge clk);
    end
    rd = dat_o;
    // Released just after the edge that samples ack high
    @(posedge clk);
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask
  // Wait for a level on the status or interrupt output, counting cycles
  task wt(input bit on_irq, input logic lvl);
    int n;
    n = 0;
    @(negedge clk);
    while ((on_irq ? irq_o : sleep_o) !== lvl) begin
      n++;
      if (n > 3000) begin
        err_total++;
        summarize();
      end
      @(negedge clk);
    end
    waited = n;
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task regs_rw;
    wb(0, 32'h40000030, 0);
    chk("ctrl reset", 32'h0, rd);
    wb(0, 32'h40000038, 0);
    chk("dur reset", 32'h0, rd);
    wb(1, 32'h40000024, 32'ha5c3_0f1e);
    wb(0, 32'h40000024, 0);
    chk("addr low", 32'ha5c30f1e, rd);
    wb(1, 32'h40000028, 32'hffffffff);
    wb(0, 32'h40000028, 0);
    chk("addr high", 32'h0001ffff, rd);
    wb(1, 32'h4000002c, 32'hffffffff);
    wb(0, 32'h4000002c, 0);
    chk("pointers", 32'hffff7fff, rd);
    wb(1, 32'h40000020, 32'hffffffff);
    wb(0, 32'h40000020, 0);
    chk("fine ro", 32'h0, rd);
    // Wake request while awake is refused
    wb(1, 32'h40000030, 32'h10);
    wb(0, 32'h40000030, 0);
    chk("soft wake idle", 32'h0, rd);
    wb(0, 32'h40000060, 0);
    chk("unmapped", 32'h0, rd);
  endtask
  // Timer expiry with interrupt leads and measured length
  task sleep_expiry;
    wb(1, 32'h40000034, 32'h8);
    wb(1, 32'h4000003c, (32'h4 << 21) | (32'h3 << 10) | 32'h1);
    wb(1, 32'h40000030, 32'h7);
    wt(1, 1);
    chk("asleep at irq set", 1, sleep_o);
    wt(1, 0);
    chk("irq high cycles", (3 - 1) * LP_DIV - 1, waited);
    chk("asleep at irq clear", 1, sleep_o);
    wt(0, 0);
    chk("release lead cycles", 1 * LP_DIV - 1, waited);
    wb(0, 32'h40000038, 0);
    chk("elapsed", 32'h8, rd);
    wb(0, 32'h40000030, 0);
    chk("ctrl after", 32'h3, rd);
    chk("run stopped", 0, run_o);
    wb(1, 32'h40000030, 32'h8);
    chk("run again", 1, run_o);
  endtask
  // Sampling freezes while asleep
  task samples;
    logic [31:0] a;
    wb(1, 32'h40000034, 32'h100);
    wb(1, 32'h40000030, 32'h80000007);
    wt(0, 1);
    wb(0, 32'h40000030, 0);
    chk("status bit", 32'h80008007, rd);
    wb(1, 32'h4000001c, 0);
    wb(0, 32'h40000020, 0);
    a = rd;
    wb(1, 32'h4000001c, 0);
    wb(0, 32'h40000020, 0);
    chk("fine frozen", a, rd);
    ext <= 1;
    repeat (40) @(posedge clk);
    chk("ext blocked", 1, sleep_o);
    wb(1, 32'h40000030, 32'h80000017);
    wt(0, 0);
    chk("soft wake delay", 0, waited);
    wb(0, 32'h40000030, 0);
    chk("soft wake clr", 32'h80000003, rd);
    wb(1, 32'h40000030, 32'h8);
    wb(1, 32'h4000001c, 0);
    wb(0, 32'h4000001c, 0);
    a = rd;
    repeat (2000) @(posedge clk);
    wb(1, 32'h4000001c, 0);
    wb(0, 32'h4000001c, 0);
    chk("slot moved", 1, rd > a);
  endtask
  // External wake with release delay of four low-power cycles
  task ext_wake;
    int h;
    h = 0;
    wb(1, 32'h40000030, 32'h7);
    wt(0, 1);
    wt(0, 0);
    chk("ext wake delay", 0, waited);
    repeat (60) begin
      h += irq_o;
      @(negedge clk);
    end
    chk("ext irq width", 1, h >= 4 * LP_DIV - 2 && h <= 4 * LP_DIV + 1);
    chk("ext irq released", 0, irq_o);
    @(posedge clk);
    ext <= 0;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    regs_rw();
    sleep_expiry();
    samples();
    ext_wake();
    summarize();
  end
endmodule
